// ===== rtl/sls_regs.svh
// constants for the strap address and led status block
`ifndef SLS_REGS_SVH
`define SLS_REGS_SVH

`define SLS_PIN_COUNT    5
`define SLS_PIN_ACT      0
`define SLS_PIN_COL      1
`define SLS_PIN_LINK     2
`define SLS_PIN_TX       3
`define SLS_PIN_RX       4
`define SLS_PINS_ALL_IN  5'h1F
`define SLS_PINS_ALL_OUT 5'h00
`define SLS_ADDR_RESET   5'h00
`define SLS_ADDR_ISOLATE 5'h00
`define SLS_LED_RESET    5'h00
`define SLS_CLK_HZ       25000000
`define SLS_RATE100_HZ   25000000
`define SLS_RATE10_HZ    2500000
`define SLS_DIV_WIDTH    4
`define SLS_DIV_RESET    4'h0

`endif

// ===== rtl/sls_pkg.sv
// types shared by the strap address and led status block
package sls_pkg;

   typedef enum logic [0:0] {
      ST_SAMPLE,
      ST_RUN
   } sls_state_t;

   typedef struct packed {
      logic rxAct;
      logic txAct;
      logic linkOk;
      logic coll;
      logic act;
   } sls_status_t;

   typedef struct packed {
      logic txEn;
      logic rxDv;
      logic linkOk;
      logic fullDuplex;
      logic speed100;
   } sls_link_t;

endpackage : sls_pkg

// ===== rtl/sls_strap_led.sv
// strap capture, management address and led status drive
`timescale 1ns/10ps
`include "sls_regs.svh"

module sls_strap_led #(
   parameter int PINS = `SLS_PIN_COUNT
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              softReset,
   input  wire sls_pkg::sls_link_t linkIn,
   input  wire logic [PINS-1:0]   strapPinIn,
   output logic [PINS-1:0]        strapPinOe_n,
   output logic                   strap0_activity_out,
   output logic                   strap1_collision_out,
   output logic                   strap2_link_ok_out,
   output logic                   strap3_tx_activity_out,
   output logic                   strap4_rx_activity_out,
   output logic [PINS-1:0]        phyAddr,
   output logic                   miiOutOe_n,
   output logic                   miiCol,
   output logic                   miiRateEn
);
   import sls_pkg::*;

   localparam int DIV10 = `SLS_CLK_HZ / `SLS_RATE10_HZ;
   localparam int DIV100 = `SLS_CLK_HZ / `SLS_RATE100_HZ;
   localparam logic [`SLS_DIV_WIDTH-1:0] DIV10_LAST = `SLS_DIV_WIDTH'(DIV10 - 1);

   // pin synchroniser, free running so levels are valid at release
   logic [PINS-1:0] strapSync1_q;
   logic [PINS-1:0] strapSync2_q;

   always_ff @(posedge core_clk) begin
      strapSync1_q <= strapPinIn;
      strapSync2_q <= strapSync1_q;
   end

   // capture state
   sls_state_t      state_q;
   sls_state_t      state_d;
   logic [PINS-1:0] strap_q;
   logic [PINS-1:0] strap_d;
   logic [PINS-1:0] pinOe_n_q;
   logic [PINS-1:0] pinOe_n_d;

   always_comb begin
      state_d   = state_q;
      strap_d   = strap_q;
      pinOe_n_d = pinOe_n_q;
      unique case (state_q)
         ST_SAMPLE: begin
            strap_d   = strapSync2_q;
            pinOe_n_d = `SLS_PINS_ALL_OUT;
            state_d   = ST_RUN;
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q   <= ST_SAMPLE;
         strap_q   <= `SLS_ADDR_RESET;
         pinOe_n_q <= `SLS_PINS_ALL_IN;
      end else begin
         state_q   <= state_d;
         strap_q   <= strap_d;
         pinOe_n_q <= pinOe_n_d;
      end
   end

   assign strapPinOe_n = pinOe_n_q;
   assign phyAddr      = strap_q;

   // mii isolation, also held until straps are known
   logic miiOff_q;
   logic miiOff_d;

   always_comb begin
      miiOff_d = (state_q != ST_RUN) || (strap_q == `SLS_ADDR_ISOLATE);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         miiOff_q <= 1'b1;
      end else begin
         miiOff_q <= miiOff_d;
      end
   end

   assign miiOutOe_n = miiOff_q;

   // link status and led drive
   sls_status_t     status;
   logic [PINS-1:0] led_q;
   logic [PINS-1:0] led_d;
   logic            col_q;
   logic            col_d;

   always_comb begin
      status.act    = linkIn.txEn || linkIn.rxDv;
      status.coll   = !linkIn.fullDuplex && linkIn.txEn && linkIn.rxDv;
      status.linkOk = linkIn.linkOk;
      status.txAct  = linkIn.txEn;
      status.rxAct  = linkIn.rxDv;
      col_d = status.coll;
      led_d = (state_q == ST_RUN) ? strap_q : strapSync2_q;
      if (state_q == ST_RUN && !softReset) begin
         led_d = strap_q ^ status;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         led_q <= `SLS_LED_RESET;
         col_q <= 1'b0;
      end else begin
         led_q <= led_d;
         col_q <= col_d;
      end
   end

   assign strap0_activity_out    = led_q[`SLS_PIN_ACT];
   assign strap1_collision_out   = led_q[`SLS_PIN_COL];
   assign strap2_link_ok_out     = led_q[`SLS_PIN_LINK];
   assign strap3_tx_activity_out = led_q[`SLS_PIN_TX];
   assign strap4_rx_activity_out = led_q[`SLS_PIN_RX];
   assign miiCol                 = col_q;

   // mii transfer rate enable
   logic [`SLS_DIV_WIDTH-1:0] div_q;
   logic [`SLS_DIV_WIDTH-1:0] div_d;
   logic                      rate_q;
   logic                      rate_d;

   always_comb begin
      div_d  = div_q;
      rate_d = 1'b0;
      if (softReset) begin
         div_d = `SLS_DIV_RESET;
      end else if (linkIn.speed100) begin
         div_d  = `SLS_DIV_RESET;
         rate_d = (DIV100 == 1);
      end else if (div_q == DIV10_LAST) begin
         div_d  = `SLS_DIV_RESET;
         rate_d = 1'b1;
      end else begin
         div_d = div_q + `SLS_DIV_WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_q  <= `SLS_DIV_RESET;
         rate_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         rate_q <= rate_d;
      end
   end

   assign miiRateEn = rate_q;

   // checks
   a_pins_input_reset:
      assert property (@(posedge core_clk) !rst_n |=> strapPinOe_n == `SLS_PINS_ALL_IN)
      else $error("pins not inputs after reset");

   a_strap_capture_exit:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (state_q == ST_SAMPLE) |=> phyAddr == $past(strapSync2_q) && state_q == ST_RUN)
      else $error("address not caught at reset exit");

   a_pins_drive_run:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         $rose(state_q == ST_RUN) |-> strapPinOe_n == `SLS_PINS_ALL_OUT ##1 strapPinOe_n == `SLS_PINS_ALL_OUT)
      else $error("pins not outputs after capture");

   a_soft_keeps_straps:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (softReset && state_q == ST_RUN) |=> $stable(phyAddr) && strapPinOe_n == `SLS_PINS_ALL_OUT)
      else $error("soft reset disturbed straps");

   a_led_idle_capture:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (state_q == ST_SAMPLE) |=> led_q == phyAddr)
      else $error("led not idle at capture");

   a_led_inverse_strap:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (state_q == ST_RUN && !softReset) |=> led_q == (phyAddr ^ $past(status)))
      else $error("led polarity wrong");

   a_mii_isolate_zero:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (state_q == ST_RUN && phyAddr == `SLS_ADDR_ISOLATE) |=> miiOutOe_n)
      else $error("mii not isolated at address zero");

   a_link_led_pin2:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (state_q == ST_RUN && !softReset && linkIn.linkOk) |=> strap2_link_ok_out == !phyAddr[`SLS_PIN_LINK])
      else $error("link led not asserted");

   a_col_half_duplex:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         linkIn.fullDuplex |=> !miiCol)
      else $error("collision in full duplex");

   a_col_tx_rx:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (!linkIn.fullDuplex && linkIn.txEn && linkIn.rxDv) |=> miiCol)
      else $error("collision missed");

   a_rate_fast:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (linkIn.speed100 && !softReset) |=> miiRateEn)
      else $error("100M rate enable missing");

   a_rate_slow_gap:
      assert property (@(posedge core_clk) disable iff (!rst_n)
         (miiRateEn && !linkIn.speed100 && !softReset) ##1 (!linkIn.speed100 && !softReset)[*8]
         |=> !miiRateEn)
      else $error("10M rate enable too early");

endmodule : sls_strap_led

// ===== verif/sls_board.sv
// board model: pull resistors and leds on the five strap pins
`timescale 1ns/10ps

module sls_board (
   input  wire logic [4:0] pull,
   input  wire logic [4:0] oeN,
   input  wire logic [4:0] drv,
   output logic [4:0]      pin
);
   // a released pin settles to its pull level
   assign pin = (oeN & pull) | (~oeN & drv);
endmodule : sls_board

// ===== verif/tb_top.sv
// self-checking bench for the strap address and led status block
`timescale 1ns/10ps

module tb_top;
   import sls_pkg::*;
   logic            core_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            softReset = 1'b0;
   sls_link_t       linkIn = '0;
   logic [4:0]      pull = 5'h00;
   logic [4:0]      strap = 5'h00;
   logic            win = 1'b0;
   logic [7:0]      rateCnt = 8'h00;
   wire logic [4:0] pinIn, oeN, drv, addr;
   wire logic       moeN, col, rateEn;
   int              num_errors = 0;
   int              check_count = 0;
   logic [24:0]     q[$];
   logic [24:0]     exp1;
   event            got;

   always #20 core_clk = ~core_clk;

   sls_strap_led u_sls_strap_led (.core_clk(core_clk), .rst_n(rst_n), .softReset(softReset), .linkIn(linkIn),
      .strapPinIn(pinIn), .strapPinOe_n(oeN), .strap0_activity_out(drv[0]), .strap1_collision_out(drv[1]),
      .strap2_link_ok_out(drv[2]), .strap3_tx_activity_out(drv[3]), .strap4_rx_activity_out(drv[4]),
      .phyAddr(addr), .miiOutOe_n(moeN), .miiCol(col), .miiRateEn(rateEn));
   sls_board u_sls_board (.pull(pull), .oeN(oeN), .drv(drv), .pin(pinIn));

   // counts rate pulses while the window is open
   always @(posedge core_clk) begin
      if (!win) rateCnt <= 8'h00;
      else if (rateEn === 1'b1) rateCnt <= rateCnt + 8'h01;
   end

   // oldest note against the outputs
   always @(got) begin
      exp1 = q.pop_front();
      check_count++;
      if ({rateCnt, addr, oeN, drv, moeN, col} !== exp1) begin
         num_errors++;
         $display("MISMATCH t=%0t exp %h got %h", $time, exp1, {rateCnt, addr, oeN, drv, moeN, col});
      end
   end

   function automatic logic [24:0] expect_obs(input logic [7:0] c);
      logic [4:0] st;
      st = {linkIn.rxDv, linkIn.txEn, linkIn.linkOk, ~linkIn.fullDuplex & linkIn.txEn & linkIn.rxDv,
            linkIn.txEn | linkIn.rxDv};
      if (softReset) st = 5'h00;
      return {c, strap, 5'h00, strap ^ st, strap == 5'h00, ~linkIn.fullDuplex & linkIn.txEn & linkIn.rxDv};
   endfunction : expect_obs

   task automatic chk(input logic [24:0] e);
      q.push_back(e);
      -> got;
   endtask : chk

   task automatic do_reset(input logic [4:0] s);
      @(negedge core_clk);
      rst_n = 1'b0;
      softReset = 1'b0;
      linkIn = '0;
      pull = s;
      strap = s;
      repeat (5) @(negedge core_clk);
      chk({8'h00, 5'h00, 5'h1F, 5'h00, 1'b1, 1'b0});
      rst_n = 1'b1;
      @(negedge core_clk);
      chk({8'h00, s, 5'h00, s, 1'b1, 1'b0});
      @(negedge core_clk);
      chk(expect_obs(8'h00));
      $display("test reset strap %h done", s);
   endtask : do_reset

   task automatic link_test;
      repeat (8) begin
         @(negedge core_clk);
         linkIn = sls_link_t'(5'($urandom));
         @(negedge core_clk);
         chk(expect_obs(8'h00));
      end
      $display("test link status done");
   endtask : link_test

   task automatic soft_test;
      @(negedge core_clk);
      linkIn = '0;
      linkIn.linkOk = 1'b1;
      linkIn.txEn = 1'b1;
      linkIn.rxDv = 1'b1;
      softReset = 1'b1;
      pull = ~strap;
      repeat (3) @(negedge core_clk);
      chk(expect_obs(8'h00));
      softReset = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(expect_obs(8'h00));
      $display("test soft reset done");
   endtask : soft_test

   task automatic rate_test(input logic fast, input int n, input logic [7:0] e);
      @(negedge core_clk);
      linkIn = '0;
      linkIn.speed100 = fast;
      repeat (2) @(negedge core_clk);
      win = 1'b1;
      repeat (n) @(negedge core_clk);
      chk(expect_obs(e));
      win = 1'b0;
      $display("test rate %0d done", fast);
   endtask : rate_test

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      void'($urandom(32'h02c65626));
      for (int i = 0; i < 6; i++) begin
         do_reset(i == 0 ? 5'h00 : i == 1 ? 5'h1F : 5'($urandom));
         link_test();
         soft_test();
         rate_test(1'b1, 20, 8'h14);
         rate_test(1'b0, 100, 8'h0A);
      end
      @(negedge core_clk);
      end_sim();
   end

   // cuts a hang short
   initial begin
      #1000000;
      num_errors++;
      end_sim();
   end
endmodule : tb_top
